// ===== src/srr_consts.svh
`ifndef SRR_CONSTS_SVH
`define SRR_CONSTS_SVH

// register byte addresses
`define SRR_CTRL_OFS 8'h00
`define SRR_STATUS_OFS 8'h04
`define SRR_LIMHI_OFS 8'h08
`define SRR_LIMLO_OFS 8'h0c
`define SRR_EFF_OFS 8'h10
`define SRR_LOCAL_OFS 8'h14
`define SRR_REMOTE_OFS 8'h18
`define SRR_BANK_BASE 2'h1

// control bit positions
`define SRR_B_RUN 0
`define SRR_B_MANUAL 1
`define SRR_B_SEL 2
`define SRR_B_EVA 3
`define SRR_B_TB 4
`define SRR_B_FOLLOW 5
`define SRR_B_RSEN 6
`define SRR_B_SRST 7
`define SRR_B_STREQ 8
`define SRR_B_ATREQ 9
`define SRR_B_BANK 10

// bank word fields
`define SRR_F_SP 2'h0
`define SRR_F_RISE 2'h1
`define SRR_F_FALL 2'h2
`define SRR_F_LAST 2'h2

// reset values and ranges
`define SRR_TB_RST 1'h1
`define SRR_VAL_MAX 16'h270f
`define SRR_VAL_MIN 16'hf831
`define SRR_SLOPE_MIN 16'h0000

// timing
`define SRR_CLK_HZ 250000000
`define SRR_TB_SEC 1
`define SRR_MIN_SEC 60

`endif

// ===== src/srr_pkg.sv
package srr_pkg;

  typedef logic signed [15:0] srr_val_t;

  typedef enum logic [2:0] {
    SRR_AT_IDLE = 3'h1,
    SRR_AT_WAIT = 3'h2,
    SRR_AT_RUN = 3'h4
  } srr_at_e;

  typedef struct packed {
    logic we;
    logic [3:0] waddr;
    srr_val_t wdata;
    logic [3:0] raddr_a;
    logic [3:0] raddr_b;
  } srr_mem_req_s;

  typedef struct packed {
    logic [15:0][15:0] words;
    srr_val_t ra;
    srr_val_t rb;
  } srr_mem_s;

  typedef struct packed {
    logic run;
    logic manual;
    logic sel_cmd;
    logic ev_assign;
    logic time_base;
    logic follow_en;
    logic rs_en_pend;
    logic rs_en_eff;
    logic st_req;
    logic st_active;
    logic [1:0] bank;
    srr_val_t lim_hi;
    srr_val_t lim_lo;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] scan;
    logic [1:0] scan_p;
    srr_val_t sh_sp;
    srr_val_t sh_rise;
    srr_val_t sh_fall;
    srr_val_t eff;
    logic ramp_done;
    srr_at_e at_st;
    logic at_active;
    srr_val_t at_sp;
    logic remote_q;
    logic track_pend;
    srr_val_t track_val;
    logic [27:0] tb_cnt;
    logic [5:0] min_cnt;
    logic run_prev;
    logic standby;
  } srr_state_s;

endpackage : srr_pkg

// ===== src/srr_bank_mem.sv
`timescale 1ns/1ps
`default_nettype none
module srr_bank_mem (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire srr_pkg::srr_mem_req_s req,
  output var srr_pkg::srr_val_t rdata_a,
  output var srr_pkg::srr_val_t rdata_b
);
  srr_pkg::srr_mem_s m_q;
  srr_pkg::srr_mem_s m_d;

  always_comb
  begin
    m_d = m_q;
    // reads see the old word on a same-cycle write
    m_d.ra = m_q.words[req.raddr_a];
    m_d.rb = m_q.words[req.raddr_b];
    if (req.we)
    begin
      m_d.words[req.waddr] = req.wdata;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      m_q <= '0;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  assign rdata_a = m_q.ra;
  assign rdata_b = m_q.rb;
endmodule : srr_bank_mem
`default_nettype wire

// ===== src/srr_setpoint_ctrl.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "srr_consts.svh"
module srr_setpoint_ctrl #(
  parameter int unsigned SEC_CYCLES = `SRR_TB_SEC * `SRR_CLK_HZ,
  parameter int unsigned CHAN_ID = 1,
  parameter bit FOUR_CH = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic event_in,
  input wire logic pv_error,
  input wire logic at_done,
  input wire srr_pkg::srr_val_t process_value,
  input wire srr_pkg::srr_val_t remote_pv,
  input wire srr_pkg::srr_val_t range_hi,
  input wire srr_pkg::srr_val_t range_lo,
  output var srr_pkg::srr_val_t effective_target,
  output var logic ramp_done,
  output var logic remote_selected,
  output var logic at_active,
  output var logic self_tuning_active,
  output var logic standby_restart
);
  localparam bit REMOTE_OK = (CHAN_ID == 1) || (FOUR_CH && (CHAN_ID == 2));

  srr_pkg::srr_state_s q;
  srr_pkg::srr_state_s d;
  srr_pkg::srr_mem_req_s mreq;
  srr_pkg::srr_val_t mrd_a;
  srr_pkg::srr_val_t mrd_b;
  srr_pkg::srr_val_t lim_min;
  srr_pkg::srr_val_t lim_max;
  srr_pkg::srr_val_t lo_eff;
  srr_pkg::srr_val_t hi_eff;
  srr_pkg::srr_val_t target;
  logic apb_wr;
  logic ctrl_wr;
  logic soft_wr;
  logic remote_sel;
  logic ramp_en;
  logic start;
  logic sec_tick;
  logic tick;
  logic track_ev;

  function automatic srr_pkg::srr_val_t clamp_to(srr_pkg::srr_val_t v, srr_pkg::srr_val_t lo,
                                                 srr_pkg::srr_val_t hi);
    if (v < lo)
    begin
      return lo;
    end
    else if (v > hi)
    begin
      return hi;
    end
    return v;
  endfunction : clamp_to

  function automatic srr_pkg::srr_val_t step_toward(srr_pkg::srr_val_t cur, srr_pkg::srr_val_t tgt,
                                                    srr_pkg::srr_val_t slope);
    logic signed [16:0] diff;
    diff = {tgt[15], tgt} - {cur[15], cur};
    if (diff < 0)
    begin
      diff = -diff;
    end
    if (diff <= {1'b0, slope})
    begin
      return tgt;
    end
    else if (tgt > cur)
    begin
      return cur + slope;
    end
    return cur - slope;
  endfunction : step_toward

  function automatic logic reg_hit(logic [7:0] a);
    if (a[1:0] != 2'h0)
    begin
      return 1'b0;
    end
    else if (a[7:6] == `SRR_BANK_BASE)
    begin
      return 1'b1;
    end
    else if (a <= `SRR_REMOTE_OFS)
    begin
      return 1'b1;
    end
    return 1'b0;
  endfunction : reg_hit

  always_comb
  begin
    d = q;
    apb_wr = psel && penable && q.pready && pwrite;
    ctrl_wr = apb_wr && (paddr == `SRR_CTRL_OFS);
    soft_wr = ctrl_wr && pwdata[`SRR_B_SRST];
    remote_sel = q.rs_en_eff && REMOTE_OK && (q.ev_assign ? event_in : q.sel_cmd);
    lim_min = (q.lim_lo < q.lim_hi) ? q.lim_lo : q.lim_hi;
    lim_max = (q.lim_lo < q.lim_hi) ? q.lim_hi : q.lim_lo;
    lo_eff = (lim_min > range_lo) ? lim_min : range_lo;
    hi_eff = (lim_max < range_hi) ? lim_max : range_hi;
    // tuning holds its latched value; remote is the other channel's value
    if (q.at_st == srr_pkg::SRR_AT_RUN)
    begin
      target = clamp_to(q.at_sp, lo_eff, hi_eff);
    end
    else if (remote_sel)
    begin
      target = clamp_to(remote_pv, lo_eff, hi_eff);
    end
    else
    begin
      target = clamp_to(q.sh_sp, lo_eff, hi_eff);
    end
    // manual mode is not a term here on purpose
    ramp_en = ((q.sh_rise != 16'h0000) || (q.sh_fall != 16'h0000)) && q.run && !pv_error;
    start = q.run && !q.run_prev;
    sec_tick = (q.tb_cnt == 28'(SEC_CYCLES - 1));
    tick = q.time_base ? (sec_tick && (q.min_cnt == 6'(`SRR_MIN_SEC - 1))) : sec_tick;
    d.tb_cnt = sec_tick ? 28'h0 : q.tb_cnt + 28'h1;
    if (sec_tick)
    begin
      d.min_cnt = (q.min_cnt == 6'(`SRR_MIN_SEC - 1)) ? 6'h0 : q.min_cnt + 6'h1;
    end

    // apb: one wait state, answer in second access cycle
    d.pready = psel && penable && !q.pready;
    d.pslverr = 1'b0;
    if (d.pready)
    begin
      d.pslverr = !reg_hit(paddr);
      d.prdata = 32'h0;
      if (paddr == `SRR_CTRL_OFS)
      begin
        d.prdata[11:0] = {q.bank, 1'b0, q.st_req, 1'b0, q.rs_en_pend, q.follow_en, q.time_base,
                          q.ev_assign, q.sel_cmd, q.manual, q.run};
      end
      else if (paddr == `SRR_STATUS_OFS)
      begin
        d.prdata[7:0] = {REMOTE_OK, q.st_active, q.at_st == srr_pkg::SRR_AT_RUN,
                         q.at_st == srr_pkg::SRR_AT_WAIT, q.rs_en_eff, q.remote_q, q.ramp_done,
                         ramp_en};
      end
      else if (paddr == `SRR_LIMHI_OFS)
      begin
        d.prdata[15:0] = q.lim_hi;
      end
      else if (paddr == `SRR_LIMLO_OFS)
      begin
        d.prdata[15:0] = q.lim_lo;
      end
      else if (paddr == `SRR_EFF_OFS)
      begin
        d.prdata[15:0] = q.eff;
      end
      else if (paddr == `SRR_LOCAL_OFS)
      begin
        d.prdata[15:0] = q.sh_sp;
      end
      else if (paddr == `SRR_REMOTE_OFS)
      begin
        d.prdata[15:0] = clamp_to(remote_pv, `SRR_VAL_MIN, `SRR_VAL_MAX);
      end
      else if ((paddr[7:6] == `SRR_BANK_BASE) && (paddr[3:2] <= `SRR_F_LAST) && !d.pslverr)
      begin
        d.prdata[15:0] = mrd_a;
      end
    end

    if (ctrl_wr)
    begin
      d.run = pwdata[`SRR_B_RUN];
      d.manual = pwdata[`SRR_B_MANUAL];
      d.sel_cmd = pwdata[`SRR_B_SEL];
      d.ev_assign = pwdata[`SRR_B_EVA];
      d.rs_en_pend = pwdata[`SRR_B_RSEN];
      d.st_req = pwdata[`SRR_B_STREQ];
      d.bank = pwdata[`SRR_B_BANK +: 2];
      if (!q.run)
      begin
        d.time_base = pwdata[`SRR_B_TB];
        d.follow_en = pwdata[`SRR_B_FOLLOW];
      end
    end
    else if (apb_wr && (paddr == `SRR_LIMHI_OFS))
    begin
      d.lim_hi = clamp_to(pwdata[15:0], `SRR_VAL_MIN, `SRR_VAL_MAX);
    end
    else if (apb_wr && (paddr == `SRR_LIMLO_OFS))
    begin
      d.lim_lo = clamp_to(pwdata[15:0], `SRR_VAL_MIN, `SRR_VAL_MAX);
    end
    // enable only lands on a soft reset; hard reset clears both copies
    if (soft_wr)
    begin
      d.rs_en_eff = d.rs_en_pend;
    end
    d.st_active = d.st_req && !d.rs_en_eff;

    // bank memory: bus write first, pending follow load waits one cycle
    mreq.raddr_a = paddr[5:2];
    mreq.raddr_b = {q.bank, q.scan};
    mreq.we = 1'b0;
    mreq.waddr = 4'h0;
    mreq.wdata = 16'h0000;
    if (apb_wr && (paddr[7:6] == `SRR_BANK_BASE) && (paddr[3:2] <= `SRR_F_LAST))
    begin
      mreq.we = 1'b1;
      mreq.waddr = paddr[5:2];
      if (paddr[3:2] == `SRR_F_SP)
      begin
        mreq.wdata = clamp_to(pwdata[15:0], `SRR_VAL_MIN, `SRR_VAL_MAX);
      end
      else
      begin
        mreq.wdata = clamp_to(pwdata[15:0], `SRR_SLOPE_MIN, `SRR_VAL_MAX);
      end
    end
    else if (q.track_pend)
    begin
      mreq.we = 1'b1;
      mreq.waddr = {q.bank, `SRR_F_SP};
      mreq.wdata = q.track_val;
      d.track_pend = 1'b0;
    end
    track_ev = q.remote_q && !remote_sel && q.follow_en;
    if (track_ev)
    begin
      d.track_pend = 1'b1;
      d.track_val = clamp_to(remote_pv, `SRR_VAL_MIN, `SRR_VAL_MAX);
    end
    d.remote_q = remote_sel;

    // shadow scan of the active bank, one field per cycle
    d.scan = (q.scan == `SRR_F_LAST) ? 2'h0 : q.scan + 2'h1;
    d.scan_p = q.scan;
    d.standby = 1'b0;
    if (q.scan_p == `SRR_F_SP)
    begin
      d.sh_sp = mrd_b;
      d.standby = !remote_sel && (mrd_b != q.sh_sp);
    end
    else if (q.scan_p == `SRR_F_RISE)
    begin
      d.sh_rise = mrd_b;
    end
    else
    begin
      d.sh_fall = mrd_b;
    end

    // ramp generator; a source switch just moves the target
    d.run_prev = q.run;
    if (!ramp_en)
    begin
      d.eff = target;
    end
    else if (start)
    begin
      d.eff = clamp_to(process_value, lo_eff, hi_eff);
    end
    else if (tick && (q.eff < target))
    begin
      d.eff = (q.sh_rise == 16'h0000) ? target : step_toward(q.eff, target, q.sh_rise);
    end
    else if (tick && (q.eff > target))
    begin
      d.eff = (q.sh_fall == 16'h0000) ? target : step_toward(q.eff, target, q.sh_fall);
    end
    d.ramp_done = (d.eff == target);

    // tuning sequencer
    case (q.at_st)
      srr_pkg::SRR_AT_IDLE:
      begin
        if (ctrl_wr && pwdata[`SRR_B_ATREQ] && q.run && !q.manual)
        begin
          d.at_st = srr_pkg::SRR_AT_WAIT;
        end
      end
      srr_pkg::SRR_AT_WAIT:
      begin
        if (!q.run || q.manual)
        begin
          d.at_st = srr_pkg::SRR_AT_IDLE;
        end
        else if (q.ramp_done)
        begin
          d.at_st = srr_pkg::SRR_AT_RUN;
          d.at_sp = target;
        end
      end
      srr_pkg::SRR_AT_RUN:
      begin
        if (at_done || !q.run || q.manual)
        begin
          d.at_st = srr_pkg::SRR_AT_IDLE;
        end
      end
      default:
      begin
        d.at_st = srr_pkg::SRR_AT_IDLE;
      end
    endcase
    d.at_active = (d.at_st == srr_pkg::SRR_AT_RUN);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.time_base <= `SRR_TB_RST;
      q.lim_hi <= `SRR_VAL_MAX;
      q.lim_lo <= `SRR_VAL_MIN;
      q.at_st <= srr_pkg::SRR_AT_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  srr_bank_mem u_mem (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .req(mreq),
    .rdata_a(mrd_a),
    .rdata_b(mrd_b)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign effective_target = q.eff;
  assign ramp_done = q.ramp_done;
  assign remote_selected = q.remote_q;
  assign at_active = q.at_active;
  assign self_tuning_active = q.st_active;
  assign standby_restart = q.standby;

  chk_rise_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (ramp_en && !start && (q.eff < target) && (q.sh_rise != 16'h0000))
    |=> (q.eff <= $past(q.eff) + $past(q.sh_rise)))
    else $error("ramp rose faster than rise slope");
  chk_stop_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!q.run || pv_error) |=> (q.eff == $past(target)))
    else $error("limiting not suspended while stopped or in error");
  chk_tb_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
    q.run |=> $stable(q.time_base))
    else $error("time base changed while running");
  chk_at_holdoff: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((q.at_st == srr_pkg::SRR_AT_WAIT) && !q.ramp_done) |=> (q.at_st != srr_pkg::SRR_AT_RUN))
    else $error("tuning began before ramp done");
  chk_st_forced: assert property (@(posedge clk_sys) disable iff (!rst_b)
    q.rs_en_eff |-> !self_tuning_active)
    else $error("self tuning active with remote enabled");
  chk_en_deferred: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !soft_wr |=> $stable(q.rs_en_eff))
    else $error("remote enable changed without soft reset");
  chk_follow_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
    track_ev |=> (q.track_pend ##[0:2] !q.track_pend))
    else $error("follow load not issued after remote to local");
  chk_done_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!ramp_en && !q.ramp_done) |=> q.ramp_done)
    else $error("done flag missing with target followed");
  chk_apb_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (psel && penable && !q.pready) |=> q.pready ##1 !q.pready)
    else $error("apb answer not one cycle after access start");
endmodule : srr_setpoint_ctrl
`default_nettype wire

// ===== sim/srr_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module srr_far_model #(
  parameter int AT_LEN = 40
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic at_active,
  input wire srr_pkg::srr_val_t remote_cmd,
  output var srr_pkg::srr_val_t process_value,
  output var srr_pkg::srr_val_t remote_pv,
  output var srr_pkg::srr_val_t range_hi,
  output var srr_pkg::srr_val_t range_lo,
  output var logic at_done
);
  int cnt;
  // own channel held still so a stop-to-run ramp has a known start
  assign process_value = 16'h0064;
  // input range narrower than the limiter defaults
  assign range_hi = 16'h01f4;
  assign range_lo = 16'hfc18;
  always_ff @(posedge clk_sys)
  begin
    remote_pv <= remote_cmd;
    at_done <= 1'b0;
    if (!rst_b || !at_active)
      cnt <= 0;
    else if (cnt == AT_LEN)
      at_done <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule : srr_far_model
`default_nettype wire

// ===== sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "srr_consts.svh"
module tb_top;
  localparam logic [31:0] C_RUN = 32'h1, C_MAN = 32'h2, C_EVA = 32'h8, C_TB = 32'h10;
  localparam logic [31:0] C_FOL = 32'h20, C_RS = 32'h40, C_SR = 32'h80, C_ST = 32'h100;
  localparam logic [31:0] C_AT = 32'h200;
  localparam logic [7:0] A_SP = 8'h40, A_RISE = 8'h44, A_FALL = 8'h48;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic event_in = 1'b0;
  logic pv_error = 1'b0;
  srr_pkg::srr_val_t remote_cmd = 16'h0000;
  srr_pkg::srr_val_t process_value, remote_pv, range_hi, range_lo, effective_target;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, errv, at_done, ramp_done, remote_selected, at_active;
  logic self_tuning_active, standby_restart;
  logic at_prev = 1'b0;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int pulses = 0;
  int k;

  always #2 clk_sys = ~clk_sys;

  srr_setpoint_ctrl #(.SEC_CYCLES(20)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .pv_error(pv_error),
    .at_done(at_done), .process_value(process_value), .remote_pv(remote_pv),
    .range_hi(range_hi), .range_lo(range_lo), .effective_target(effective_target),
    .ramp_done(ramp_done), .remote_selected(remote_selected), .at_active(at_active),
    .self_tuning_active(self_tuning_active), .standby_restart(standby_restart));

  srr_far_model far (.clk_sys(clk_sys), .rst_b(rst_b), .at_active(at_active),
    .remote_cmd(remote_cmd), .process_value(process_value), .remote_pv(remote_pv),
    .range_hi(range_hi), .range_lo(range_lo), .at_done(at_done));

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk_sys);
    end
    if (pready !== 1'b1)
      errors++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] mask = 32'hffffffff);
    xfer(1'b0, a, 32'h0);
    chk(rdv & mask, exp);
  endtask : rd

  // target change needs a few cycles to reach the ramp, so skip those first
  task automatic wait_done(input int lo, input int hi);
    int n;
    n = 0;
    repeat (6) @(posedge clk_sys);
    while (ramp_done !== 1'b1 && n < 3000)
    begin
      n++;
      @(posedge clk_sys);
    end
    chk(n >= lo && n <= hi, 32'h1);
  endtask : wait_done

  always @(posedge clk_sys)
  begin
    cyc++;
    if (standby_restart === 1'b1)
      pulses++;
    if (at_active === 1'b1 && at_prev !== 1'b1)
      chk(ramp_done, 32'h1);
    at_prev = at_active;
    if (cyc == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(`SRR_CTRL_OFS, 32'h10);
    rd(`SRR_LIMHI_OFS, 32'h270f);
    rd(`SRR_LIMLO_OFS, 32'hf831);
    rd(A_RISE, 32'h0);
    rd(A_FALL, 32'h0);
    rd(`SRR_STATUS_OFS, 32'h80, 32'h89);
    xfer(1'b0, 8'h20, 32'h0);
    chk(errv, 32'h1);
    wr(A_RISE, 32'h4e20);
    rd(A_RISE, 32'h270f);
    wr(A_SP, 32'hffffec78);
    // the shadow copy of the bank lags a write by up to four cycles
    repeat (4) @(posedge clk_sys);
    rd(`SRR_LOCAL_OFS, 32'hf831);
    wr(`SRR_CTRL_OFS, C_RUN | C_TB);
    wr(`SRR_CTRL_OFS, C_RUN);
    rd(`SRR_CTRL_OFS, 32'h11);
    wr(`SRR_CTRL_OFS, 32'h0);
    rd(`SRR_CTRL_OFS, 32'h10);
    wr(`SRR_CTRL_OFS, 32'h0);
    rd(`SRR_CTRL_OFS, 32'h0);
    wr(A_RISE, 32'h5);
    wr(A_FALL, 32'h0);
    wr(A_SP, 32'h82);
    repeat (8) @(posedge clk_sys);
    rd(`SRR_EFF_OFS, 32'h82);
    rd(`SRR_STATUS_OFS, 32'h0, 32'h1);
    wr(`SRR_CTRL_OFS, C_RUN);
    wr(`SRR_CTRL_OFS, C_RUN | C_AT);
    rd(`SRR_STATUS_OFS, 32'h11, 32'h31);
    wait_done(60, 130);
    rd(`SRR_EFF_OFS, 32'h82);
    chk(effective_target, 32'h82);
    repeat (60) @(posedge clk_sys);
    chk(at_active, 32'h0);
    wr(A_FALL, 32'ha);
    wr(`SRR_CTRL_OFS, C_RUN | C_MAN);
    wr(A_SP, 32'h64);
    wait_done(30, 70);
    rd(`SRR_EFF_OFS, 32'h64);
    wr(`SRR_CTRL_OFS, C_RUN);
    wr(A_SP, 32'h82);
    wait_done(90, 130);
    wr(A_RISE, 32'h0);
    wr(A_FALL, 32'h0);
    repeat (4) @(posedge clk_sys);
    rd(`SRR_STATUS_OFS, 32'h0, 32'h1);
    wr(`SRR_LIMHI_OFS, 32'h78);
    wr(A_SP, 32'hc8);
    repeat (8) @(posedge clk_sys);
    rd(`SRR_EFF_OFS, 32'h78);
    rd(`SRR_LOCAL_OFS, 32'hc8);
    wr(`SRR_LIMHI_OFS, 32'h270f);
    wr(A_SP, 32'h2bc);
    repeat (8) @(posedge clk_sys);
    rd(`SRR_EFF_OFS, 32'h1f4);
    wr(A_FALL, 32'h5);
    pv_error <= 1'b1;
    wr(A_SP, 32'h64);
    repeat (8) @(posedge clk_sys);
    rd(`SRR_EFF_OFS, 32'h64);
    pv_error <= 1'b0;
    wr(A_RISE, 32'h14);
    wr(`SRR_CTRL_OFS, C_ST);
    wr(`SRR_CTRL_OFS, C_ST | C_RS);
    rd(`SRR_STATUS_OFS, 32'h40, 32'h48);
    wr(`SRR_CTRL_OFS, C_ST | C_RS | C_SR);
    rd(`SRR_STATUS_OFS, 32'h08, 32'h48);
    chk(self_tuning_active, 32'h0);
    wr(`SRR_CTRL_OFS, C_RS | C_FOL | C_EVA);
    remote_cmd <= 16'h00fa;
    rd(`SRR_REMOTE_OFS, 32'hfa);
    wr(`SRR_CTRL_OFS, C_RUN | C_RS | C_FOL | C_EVA);
    repeat (8) @(posedge clk_sys);
    chk(remote_selected, 32'h0);
    event_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(remote_selected, 32'h1);
    wait_done(110, 170);
    rd(`SRR_EFF_OFS, 32'hfa);
    k = pulses;
    remote_cmd <= 16'h0104;
    repeat (40) @(posedge clk_sys);
    chk(pulses, k);
    wr(`SRR_CTRL_OFS, C_RUN | C_RS | C_FOL | C_EVA | C_AT);
    repeat (8) @(posedge clk_sys);
    remote_cmd <= 16'h012c;
    repeat (10) @(posedge clk_sys);
    rd(`SRR_EFF_OFS, 32'h104);
    repeat (40) @(posedge clk_sys);
    wait_done(0, 60);
    rd(`SRR_EFF_OFS, 32'h12c);
    event_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(`SRR_LOCAL_OFS, 32'h12c);
    k = pulses;
    wr(A_SP, 32'h8c);
    // pulse lands up to five edges after the write
    repeat (6) @(posedge clk_sys);
    chk(pulses, k + 1);
    // first stop keeps follow, the second write while stopped clears it
    wr(`SRR_CTRL_OFS, C_RS | C_EVA);
    wr(`SRR_CTRL_OFS, C_RS | C_EVA);
    wr(`SRR_CTRL_OFS, C_RUN | C_RS | C_EVA);
    event_in <= 1'b1;
    repeat (6) @(posedge clk_sys);
    event_in <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(`SRR_LOCAL_OFS, 32'h8c);
    // minute base: two steps of five take two minute ticks, not two seconds
    wr(`SRR_CTRL_OFS, 32'h0);
    wr(`SRR_CTRL_OFS, C_TB);
    rd(`SRR_CTRL_OFS, 32'h10);
    wr(A_RISE, 32'h5);
    wr(A_SP, 32'h6e);
    wr(`SRR_CTRL_OFS, C_RUN | C_TB);
    wait_done(1150, 2450);
    rd(`SRR_EFF_OFS, 32'h6e);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
